//--- hw/pgate_pkg.sv
// Constants shared by the port pin override and sleep gating block.
// How it works
// - Deep sleep modes raise one shared clamp that grounds every pin input.
// - A pin with its external interrupt enabled escapes the sleep clamp.
// - A high pin with interrupt disabled flags an event when the clamp lifts.
// - All pull-ups are off while reset is active.
// - Without override, pull-up is on only for direction 0, value 1, disable 0.
// - With pull-up override enabled, pull-up follows the override value.
// - Driver enable follows direction override when enabled, else direction bit.
// - Driven level follows value override when enabled, else the value bit.
// - Toggle override from a peripheral inverts the output value bit.
// - Input enable follows its override, else on when awake, clamp gates it.
// - Peripheral input is taken after the clamp, before the pin synchroniser.
// - Strobes shared per port; clock, clamp and pull-up disable shared by all.
// - Control register keeps bits 7, 4, 1 and 0; other bits read zero.
// - Direction one makes an output; zero an input where value requests pull-up.
// - Writing one to a pin input bit inverts the matching output value bit.
// - The global pull-up disable turns off every pull-up that has no override enabled.
// - Pin reads pass a clock-high latch then a rising-edge register.
package pgate_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // Register offsets on the plain register port.
  localparam logic [2:0] OFS_PORT_OUT = 3'h0;
  localparam logic [2:0] OFS_PORT_DIR = 3'h1;
  localparam logic [2:0] OFS_PIN_IN = 3'h2;
  localparam logic [2:0] OFS_MCU_CONTROL = 3'h3;
  localparam logic [2:0] OFS_IRQ_STATUS = 3'h4;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h5;
  // Control register field positions and writable mask.
  localparam int BIT_DEBUG_IFACE_DISABLE = 7;
  localparam int BIT_GLOBAL_PULLUP_OFF = 4;
  localparam int BIT_VECTOR_TABLE_SELECT = 1;
  localparam int BIT_VECTOR_CHANGE_ENABLE = 0;
  localparam logic [7:0] MCU_CONTROL_RW_MASK = 8'h93;
  // Reset values.
  localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  // Sleep mode codes presented by the sleep controller.
  localparam logic [2:0] SLP_IDLE = 3'h0;
  localparam logic [2:0] SLP_POWER_DOWN = 3'h1;
  localparam logic [2:0] SLP_POWER_SAVE = 3'h2;
  localparam logic [2:0] SLP_STANDBY = 3'h3;
  localparam logic [2:0] SLP_EXT_STANDBY = 3'h4;
endpackage : pgate_pkg

//--- hw/pgate_ovr_if.sv
// Per-pin override signals passed between the port top and its pin logic.
`timescale 1ns/100ps
`default_nettype none
interface pgate_ovr_if #(parameter int N = 8);
  logic [N-1:0] pullup_override_en;
  logic [N-1:0] pullup_override_val;
  logic [N-1:0] dir_override_en;
  logic [N-1:0] dir_override_val;
  logic [N-1:0] outval_override_en;
  logic [N-1:0] outval_override_val;
  logic [N-1:0] input_en_override_en;
  logic [N-1:0] input_en_override_val;
  // The top fills the overrides; the pin logic only reads them.
  modport src (output pullup_override_en, pullup_override_val,
    dir_override_en, dir_override_val, outval_override_en,
    outval_override_val, input_en_override_en, input_en_override_val);
  modport pin (input pullup_override_en, pullup_override_val,
    dir_override_en, dir_override_val, outval_override_en,
    outval_override_val, input_en_override_en, input_en_override_val);
endinterface : pgate_ovr_if
`default_nettype wire

//--- hw/pgate_pin.sv
// Combinational pin control: pull-up, driver, level and input gating.
`timescale 1ns/100ps
`default_nettype none
module pgate_pin #(
  parameter int N = 8
) (
  pgate_ovr_if.pin ovr, // Override signals, one bit per pin.
  input wire logic [N-1:0] pin_direction_bit, // Direction register.
  input wire logic [N-1:0] pin_out_value_bit, // Output value register.
  input wire logic global_pullup_off, // Shared pull-up disable.
  input wire logic sleep_clamp, // Shared deep sleep clamp.
  input wire logic [N-1:0] ext_int_en, // Pin interrupt enables.
  input wire logic [N-1:0] pad_in, // Level seen at the pad.
  output logic [N-1:0] pullup_next, // Pull-up request.
  output logic [N-1:0] drive_en_next, // Output driver enable.
  output logic [N-1:0] drive_level_next, // Driven level.
  output logic [N-1:0] gated_in // Schmitt output after the clamp.
);
  logic [N-1:0] plain_pullup;
  logic [N-1:0] input_en;

  // Pull-up, driver and level selection per pin.
  always_comb begin
    plain_pullup = ~pin_direction_bit & pin_out_value_bit &
                   {N{~global_pullup_off}};
    pullup_next = (ovr.pullup_override_en & ovr.pullup_override_val) |
                  (~ovr.pullup_override_en & plain_pullup);
    drive_en_next = (ovr.dir_override_en & ovr.dir_override_val) |
                    (~ovr.dir_override_en & pin_direction_bit);
    drive_level_next = (ovr.outval_override_en & ovr.outval_override_val) |
                       (~ovr.outval_override_en & pin_out_value_bit);
  end

  // Input enable; the clamp grounds the signal ahead of the Schmitt stage.
  always_comb begin
    input_en = (ovr.input_en_override_en & ovr.input_en_override_val) |
               (~ovr.input_en_override_en &
                ({N{~sleep_clamp}} | ext_int_en));
    gated_in = pad_in & input_en;
  end
endmodule // pgate_pin
`default_nettype wire

//--- hw/pgate_sync.sv
// Pin read synchroniser: clock-high latch followed by a rising-edge flop.
`timescale 1ns/100ps
`default_nettype none
module pgate_sync #(
  parameter int N = 8
) (
  input wire logic clk, // Port clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic [N-1:0] d, // Gated pin inputs.
  output logic [N-1:0] q // Synchronised pin values.
);
  logic [N-1:0] hold;
  logic [N-1:0] next_q;

  always_latch begin
    if (clk) begin
      hold <= d;
    end
  end

  // The flop takes what the latch held; nothing else reads the latch.
  always_comb begin
    next_q = hold;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule // pgate_sync
`default_nettype wire

//--- hw/pgate_port.sv
// One I/O port: registers, overrides, sleep clamp, pin read and events.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pgate_port #(
  parameter int N = 8
) (
  input wire logic clk, // Port clock, 10 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic [pgate_pkg::ADDR_W-1:0] addr, // Register address.
  input wire logic [pgate_pkg::DATA_W-1:0] wdata, // Write data.
  input wire logic wr_en, // Write strobe.
  input wire logic rd_en, // Read strobe.
  output logic [pgate_pkg::DATA_W-1:0] rdata, // Read data, next cycle.
  input wire logic sleep_req, // Core is asleep.
  input wire logic [2:0] sleep_mode, // Sleep mode code.
  input wire logic [N-1:0] pullup_override_en, // Pull-up override enable.
  input wire logic [N-1:0] pullup_override_val, // Pull-up override value.
  input wire logic [N-1:0] dir_override_en, // Direction override enable.
  input wire logic [N-1:0] dir_override_val, // Direction override value.
  input wire logic [N-1:0] outval_override_en, // Level override enable.
  input wire logic [N-1:0] outval_override_val, // Level override value.
  input wire logic [N-1:0] toggle_override_en, // Toggle override enable.
  input wire logic [N-1:0] input_en_override_en, // Input override enable.
  input wire logic [N-1:0] input_en_override_val, // Input override value.
  input wire logic [N-1:0] pad_in, // Pad input levels.
  output logic [N-1:0] alt_func_input, // Unsynchronised input to peripherals.
  output logic [N-1:0] pad_out, // Driven level.
  output logic [N-1:0] pad_oe, // Driver enable, high drives the pad.
  output logic [N-1:0] pullup_en, // Pull-up resistor enable.
  output logic debug_iface_disable, // Control bit 7.
  output logic vector_table_select, // Control bit 1.
  output logic vector_change_enable, // Control bit 0.
  output logic irq // Level interrupt.
);
  // Register bus is eight bits wide, so a port holds eight pins at most.
  if (N < 1 || N > pgate_pkg::DATA_W) begin : g_bad_width
    $error("pgate_port: N must lie between 1 and 8");
  end

  // overrides enter from the owning peripherals
  pgate_ovr_if #(.N(N)) ovr ();
  assign ovr.pullup_override_en = pullup_override_en;
  assign ovr.pullup_override_val = pullup_override_val;
  assign ovr.dir_override_en = dir_override_en;
  assign ovr.dir_override_val = dir_override_val;
  assign ovr.outval_override_en = outval_override_en;
  assign ovr.outval_override_val = outval_override_val;
  assign ovr.input_en_override_en = input_en_override_en;
  assign ovr.input_en_override_val = input_en_override_val;

  logic [N-1:0] pin_direction_bit;
  logic [N-1:0] pin_out_value_bit;
  logic [pgate_pkg::DATA_W-1:0] mcu_control;
  logic [N-1:0] irq_status;
  logic [N-1:0] irq_mask;
  logic sleep_clamp;
  logic [N-1:0] pin_sync;
  logic [N-1:0] pin_prev;
  logic [N-1:0] next_pin_direction_bit;
  logic [N-1:0] next_pin_out_value_bit;
  logic [pgate_pkg::DATA_W-1:0] next_mcu_control;
  logic [N-1:0] next_irq_status;
  logic [N-1:0] next_irq_mask;
  logic next_sleep_clamp;
  logic [N-1:0] next_pin_prev;
  logic [pgate_pkg::DATA_W-1:0] next_rdata;
  logic next_irq;
  logic [N-1:0] pullup_next;
  logic [N-1:0] drive_en_next;
  logic [N-1:0] drive_level_next;
  logic [N-1:0] gated_in;
  logic global_pullup_off;
  logic [N-1:0] wdata_n;

  // Narrow write data to the pin count once for all pin registers.
  function automatic logic [N-1:0] pin_bits(
    input logic [pgate_pkg::DATA_W-1:0] v);
    pin_bits = v[N-1:0];
  endfunction

  // Widen a pin vector to the bus width, upper bits reading zero.
  function automatic logic [pgate_pkg::DATA_W-1:0] bus_bits(
    input logic [N-1:0] v);
    logic [pgate_pkg::DATA_W-1:0] r;
    r = '0;
    r[N-1:0] = v;
    bus_bits = r;
  endfunction

  assign wdata_n = pin_bits(wdata);
  // one pull-up disable shared by every pin
  assign global_pullup_off = mcu_control[pgate_pkg::BIT_GLOBAL_PULLUP_OFF];

  // Mask bits double as the pin interrupt enables that bypass the clamp.
  pgate_pin #(.N(N)) u_pin (
    .ovr(ovr),
    .pin_direction_bit(pin_direction_bit),
    .pin_out_value_bit(pin_out_value_bit),
    .global_pullup_off(global_pullup_off),
    .sleep_clamp(sleep_clamp),
    .ext_int_en(irq_mask),
    .pad_in(pad_in),
    .pullup_next(pullup_next),
    .drive_en_next(drive_en_next),
    .drive_level_next(drive_level_next),
    .gated_in(gated_in)
  );

  // peripheral input taken ahead of the synchroniser
  assign alt_func_input = gated_in;

  pgate_sync #(.N(N)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(gated_in),
    .q(pin_sync)
  );

  // Shared sleep clamp; idle and extended standby leave inputs live.
  always_comb begin
    next_sleep_clamp = 1'b0;
    if (sleep_req) begin
      case (sleep_mode)
        pgate_pkg::SLP_POWER_DOWN: next_sleep_clamp = 1'b1;
        pgate_pkg::SLP_POWER_SAVE: next_sleep_clamp = 1'b1;
        pgate_pkg::SLP_STANDBY: next_sleep_clamp = 1'b1;
        default: next_sleep_clamp = 1'b0;
      endcase
    end
  end

  // Port registers; strobes are common to all pins of this port.
  always_comb begin
    next_pin_direction_bit = pin_direction_bit;
    next_pin_out_value_bit = pin_out_value_bit;
    next_mcu_control = mcu_control;
    next_irq_mask = irq_mask;
    if (wr_en) begin
      case (addr)
        pgate_pkg::OFS_PORT_OUT: next_pin_out_value_bit = wdata_n;
        pgate_pkg::OFS_PORT_DIR: next_pin_direction_bit = wdata_n;
        pgate_pkg::OFS_PIN_IN:
          next_pin_out_value_bit = pin_out_value_bit ^ wdata_n;
        pgate_pkg::OFS_MCU_CONTROL:
          next_mcu_control = wdata & pgate_pkg::MCU_CONTROL_RW_MASK;
        pgate_pkg::OFS_IRQ_MASK: next_irq_mask = wdata_n;
        default: next_mcu_control = mcu_control;
      endcase
    end
    next_pin_out_value_bit = next_pin_out_value_bit ^ toggle_override_en;
  end

  // Pin events: any change of the synchronised value sets a sticky flag.
  // Because the clamp sits before the synchroniser, a high pin reads low
  // during deep sleep and rises on wake, which flags it as an event.
  always_comb begin
    next_pin_prev = pin_sync;
    next_irq_status = irq_status;
    if (wr_en && addr == pgate_pkg::OFS_IRQ_STATUS) begin
      next_irq_status = irq_status & ~wdata_n;
    end
    // release of clamp flags the change
    next_irq_status = next_irq_status | (pin_sync ^ pin_prev);
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // Read data for the cycle after the strobe; unmapped offsets read zero.
  always_comb begin
    next_rdata = '0;
    if (rd_en) begin
      case (addr)
        pgate_pkg::OFS_PORT_OUT: next_rdata = bus_bits(pin_out_value_bit);
        pgate_pkg::OFS_PORT_DIR: next_rdata = bus_bits(pin_direction_bit);
        pgate_pkg::OFS_PIN_IN: next_rdata = bus_bits(pin_sync);
        pgate_pkg::OFS_MCU_CONTROL: next_rdata = mcu_control;
        pgate_pkg::OFS_IRQ_STATUS: next_rdata = bus_bits(irq_status);
        pgate_pkg::OFS_IRQ_MASK: next_rdata = bus_bits(irq_mask);
        default: next_rdata = '0;
      endcase
    end
  end

  // State and output registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_direction_bit <= pin_bits(pgate_pkg::PORT_RESET);
      pin_out_value_bit <= pin_bits(pgate_pkg::PORT_RESET);
      mcu_control <= pgate_pkg::MCU_CONTROL_RESET;
      irq_status <= '0;
      irq_mask <= '0;
      sleep_clamp <= 1'b0;
      pin_prev <= '0;
      rdata <= '0;
      irq <= 1'b0;
      pad_out <= '0;
      pad_oe <= '0;
      pullup_en <= '0;
      debug_iface_disable <= 1'b0;
      vector_table_select <= 1'b0;
      vector_change_enable <= 1'b0;
    end else begin
      pin_direction_bit <= next_pin_direction_bit;
      pin_out_value_bit <= next_pin_out_value_bit;
      mcu_control <= next_mcu_control;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      sleep_clamp <= next_sleep_clamp;
      pin_prev <= next_pin_prev;
      rdata <= next_rdata;
      irq <= next_irq;
      // Pad controls follow the pin logic one edge later.
      pad_out <= drive_level_next;
      pad_oe <= drive_en_next;
      pullup_en <= pullup_next;
      debug_iface_disable <=
        next_mcu_control[pgate_pkg::BIT_DEBUG_IFACE_DISABLE];
      vector_table_select <=
        next_mcu_control[pgate_pkg::BIT_VECTOR_TABLE_SELECT];
      vector_change_enable <=
        next_mcu_control[pgate_pkg::BIT_VECTOR_CHANGE_ENABLE];
    end
  end
endmodule // pgate_port
`default_nettype wire

//--- test/pgate_port_checker.sv
// Assertion checker for the port pin override and sleep gating block.
`timescale 1ns/100ps
`default_nettype none
module pgate_port_checker #(
  parameter int N = 8
) (
  input wire logic clk, rst_b, wr_en, rd_en, sleep_req, // Clock and strobes.
  input wire logic [pgate_pkg::ADDR_W-1:0] addr, // Register address.
  input wire logic [2:0] sleep_mode, // Sleep mode code.
  input wire logic [7:0] wdata, rdata, // Register data.
  input wire logic [N-1:0] pullup_override_en, pullup_override_val,
  input wire logic [N-1:0] dir_override_en, dir_override_val,
  input wire logic [N-1:0] outval_override_en, outval_override_val,
  input wire logic [N-1:0] input_en_override_en, input_en_override_val,
  input wire logic [N-1:0] pad_in, alt_func_input, pad_out, pad_oe,
  input wire logic [N-1:0] pullup_en, // Pull-up enables.
  input wire logic debug_iface_disable, vector_table_select,
  input wire logic vector_change_enable // Control bit 0.
);
  logic [N-1:0] q_pue, q_puv, q_dre, q_drv, q_lve, q_lvv, mask_q;
  logic [7:0] wd_q;
  logic clamp_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Delayed copies line up with the one-cycle pin output latency.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {q_pue, q_puv, q_dre, q_drv, q_lve, q_lvv, mask_q} <= '0;
      wd_q <= 8'h00;
      clamp_q <= 1'b0;
    end else begin
      {q_pue, q_puv, q_dre, q_drv} <= {pullup_override_en,
        pullup_override_val, dir_override_en, dir_override_val};
      {q_lve, q_lvv} <= {outval_override_en, outval_override_val};
      wd_q <= wdata;
      clamp_q <= sleep_req && (sleep_mode inside {pgate_pkg::SLP_POWER_DOWN,
        pgate_pkg::SLP_POWER_SAVE, pgate_pkg::SLP_STANDBY});
      if (wr_en && addr == pgate_pkg::OFS_IRQ_MASK) begin
        mask_q <= wdata[N-1:0];
      end
    end
  end
  property p_reset_pullup;
    $rose(rst_b) |-> pullup_en == '0;
  endproperty
  a_reset_pullup: assert property (p_reset_pullup)
    else $error("pull-up on at reset release");
  property p_pu_ovr;
    (pullup_en & q_pue) == (q_pue & q_puv);
  endproperty
  a_pu_ovr: assert property (p_pu_ovr)
    else $error("pull-up ignores its override");
  property p_dir_ovr;
    (pad_oe & q_dre) == (q_dre & q_drv);
  endproperty
  a_dir_ovr: assert property (p_dir_ovr)
    else $error("driver enable ignores its override");
  property p_lvl_ovr;
    (pad_out & q_lve) == (q_lve & q_lvv);
  endproperty
  a_lvl_ovr: assert property (p_lvl_ovr)
    else $error("driven level ignores its override");
  property p_in_ovr;
    (alt_func_input & input_en_override_en) ==
      (pad_in & input_en_override_en & input_en_override_val);
  endproperty
  a_in_ovr: assert property (p_in_ovr)
    else $error("input enable ignores its override");
  property p_sleep_clamp;
    (alt_func_input & ~input_en_override_en) ==
      (pad_in & ~input_en_override_en & (clamp_q ? mask_q : '1));
  endproperty
  a_sleep_clamp: assert property (p_sleep_clamp)
    else $error("peripheral input not clamped as expected");
  property p_ctl_wr;
    wr_en && addr == pgate_pkg::OFS_MCU_CONTROL |=>
      {debug_iface_disable, vector_table_select, vector_change_enable} ==
      {wd_q[7], wd_q[1], wd_q[0]};
  endproperty
  a_ctl_wr: assert property (p_ctl_wr)
    else $error("control outputs differ from written bits");
  property p_ctl_rd;
    rd_en && addr == pgate_pkg::OFS_MCU_CONTROL |=>
      (rdata & ~pgate_pkg::MCU_CONTROL_RW_MASK) == 8'h00 &&
      rdata[7] == debug_iface_disable;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd)
    else $error("control read shows reserved or stale bits");
  // Coverage of the main scenarios.
  c_clamp: cover property (clamp_q && (pad_in & ~mask_q) != '0);
  c_ctl: cover property (wr_en && addr == pgate_pkg::OFS_MCU_CONTROL);
  c_pu_ovr: cover property ((q_pue & q_puv) != '0);
endmodule // pgate_port_checker
bind pgate_port pgate_port_checker #(.N(N)) u_chk (
  .clk(clk), .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en),
  .sleep_req(sleep_req), .addr(addr), .sleep_mode(sleep_mode),
  .wdata(wdata), .rdata(rdata), .pullup_override_en(pullup_override_en),
  .pullup_override_val(pullup_override_val),
  .dir_override_en(dir_override_en), .dir_override_val(dir_override_val),
  .outval_override_en(outval_override_en),
  .outval_override_val(outval_override_val),
  .input_en_override_en(input_en_override_en),
  .input_en_override_val(input_en_override_val), .pad_in(pad_in),
  .alt_func_input(alt_func_input), .pad_out(pad_out), .pad_oe(pad_oe),
  .pullup_en(pullup_en), .debug_iface_disable(debug_iface_disable),
  .vector_table_select(vector_table_select),
  .vector_change_enable(vector_change_enable)
);
`default_nettype wire

//--- test/pgate_periph.sv
// Model of the peripherals that drive the pin override signals.
`timescale 1ns/100ps
`default_nettype none
module pgate_periph (
  input wire logic clk, // Port clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic en, // Alternate functions active.
  input wire logic [31:0] rnd, // Override pattern.
  input wire logic [7:0] tog, // Toggle requests.
  input wire logic [7:0] din, // Raw pin input from the port.
  output logic [7:0] pullup_override_en, // Pull-up override enable.
  output logic [7:0] pullup_override_val, // Pull-up override value.
  output logic [7:0] dir_override_en, // Direction override enable.
  output logic [7:0] dir_override_val, // Direction override value.
  output logic [7:0] outval_override_en, // Level override enable.
  output logic [7:0] outval_override_val, // Level override value.
  output logic [7:0] input_en_override_en, // Input override enable.
  output logic [7:0] input_en_override_val, // Input override value.
  output logic [7:0] toggle_override_en, // Toggle override enable.
  output logic [7:0] sync_in // Raw input after the model's own synchroniser.
);
  logic [7:0] din_s1;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {pullup_override_en, pullup_override_val, dir_override_en,
        dir_override_val, outval_override_en, outval_override_val,
        input_en_override_en, input_en_override_val} <= 64'h0000_0000_0000_0000;
      toggle_override_en <= 8'h00;
    end else begin
      {pullup_override_en, pullup_override_val, dir_override_en,
        dir_override_val, outval_override_en, outval_override_val,
        input_en_override_en, input_en_override_val} <= en ?
        {rnd, rnd[15:0] ^ rnd[31:16], ~rnd[31:16]} : 64'h0000_0000_0000_0000;
      toggle_override_en <= tog;
    end
  end
  // own synchroniser on the raw input, since it is not a clock here.
  always_ff @(posedge clk) begin
    din_s1 <= din;
    sync_in <= din_s1;
  end
endmodule // pgate_periph
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the port pin override and sleep gating block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rst_b, wr_en, rd_en, sleep_req, p_en, irq, dbg, vts, vce;
  logic rd_q = 1'b0;
  logic [2:0] addr, sleep_mode;
  logic [7:0] wdata, rdata, pad_in, tog, pad_out, pad_oe, pullup_en, afi;
  logic [7:0] pue, puv, dre, drv, lve, lvv, ine, inv, tge, d, v, e, sin;
  logic [31:0] rnd;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  int seed;
  pgate_port #(.N(8)) dut (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .sleep_req(sleep_req), .sleep_mode(sleep_mode),
    .pullup_override_en(pue), .pullup_override_val(puv),
    .dir_override_en(dre), .dir_override_val(drv),
    .outval_override_en(lve), .outval_override_val(lvv),
    .toggle_override_en(tge), .input_en_override_en(ine),
    .input_en_override_val(inv), .pad_in(pad_in), .alt_func_input(afi),
    .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en),
    .debug_iface_disable(dbg), .vector_table_select(vts),
    .vector_change_enable(vce), .irq(irq));
  pgate_periph u_periph (.clk(clk), .rst_b(rst_b), .en(p_en), .rnd(rnd),
    .tog(tog), .din(afi), .pullup_override_en(pue),
    .pullup_override_val(puv), .dir_override_en(dre),
    .dir_override_val(drv), .outval_override_en(lve),
    .outval_override_val(lvv), .input_en_override_en(ine),
    .input_en_override_val(inv), .toggle_override_en(tge), .sync_in(sin));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] dat);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= dat;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // The expected value waits in the queue until the read data appear.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back(exp);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge clk) begin
    if (rd_q && exp_q.size() > 0) begin
      chk(rdata, exp_q.pop_front());
    end
    rd_q <= rd_en;
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A hang is cut short here and counted as a mismatch.
  initial begin
    wt(20000);
    err_count++;
    close_out();
  end
  initial begin
    seed = 32'h4430;
    {rst_b, wr_en, rd_en, sleep_req, p_en} = 5'h00;
    {addr, sleep_mode, wdata, pad_in, tog, rnd} = '0;
    wt(3);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    wr(pgate_pkg::OFS_MCU_CONTROL, 8'hFF);
    rd(pgate_pkg::OFS_MCU_CONTROL, 8'h93);
    chk({5'h00, dbg, vts, vce}, 8'h07);
    // Pull-up, driver and level from the registers alone.
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      v = 8'($random(seed));
      wr(pgate_pkg::OFS_PORT_DIR, d);
      wr(pgate_pkg::OFS_PORT_OUT, v);
      wr(pgate_pkg::OFS_MCU_CONTROL, {3'h0, i[0], 4'h0});
      wt(2);
      chk(pullup_en, ~d & v & {8{~i[0]}});
      chk(pad_oe, d);
      chk(pad_out, v);
    end
    wr(pgate_pkg::OFS_MCU_CONTROL, 8'h00);
    // Random overrides from the peripherals.
    p_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rnd <= $random(seed);
      pad_in <= 8'($random(seed));
      wt(3);
      chk(pullup_en, (pue & puv) | (~pue & ~d & v));
      chk(pad_oe, (dre & drv) | (~dre & d));
      chk(pad_out, (lve & lvv) | (~lve & v));
      chk(afi, pad_in & (~ine | inv));
    end
    p_en <= 1'b0;
    wr(pgate_pkg::OFS_PORT_OUT, 8'h5A);
    wr(pgate_pkg::OFS_PIN_IN, 8'h0F);
    rd(pgate_pkg::OFS_PORT_OUT, 8'h55);
    tog <= 8'h80;
    wt(1);
    tog <= 8'h00;
    wt(3);
    rd(pgate_pkg::OFS_PORT_OUT, 8'hD5);
    // Pin read, change events and the masked interrupt.
    pad_in <= 8'h00;
    wt(3);
    wr(pgate_pkg::OFS_IRQ_STATUS, 8'hFF);
    wr(pgate_pkg::OFS_IRQ_MASK, 8'h00);
    pad_in <= 8'h03;
    wt(3);
    rd(pgate_pkg::OFS_PIN_IN, 8'h03);
    chk(sin, 8'h03);
    rd(pgate_pkg::OFS_IRQ_STATUS, 8'h03);
    chk({7'h00, irq}, 8'h00);
    wr(pgate_pkg::OFS_IRQ_MASK, 8'h01);
    wt(2);
    chk({7'h00, irq}, 8'h01);
    wr(pgate_pkg::OFS_IRQ_STATUS, 8'h01);
    wt(2);
    chk({7'h00, irq}, 8'h00);
    rd(pgate_pkg::OFS_IRQ_STATUS, 8'h02);
    // Every sleep mode; only the deep ones clamp pin 1, pin 0 is bypassed.
    for (int m = 0; m < 5; m++) begin
      e = (m >= 1 && m <= 3) ? 8'h01 : 8'h03;
      sleep_mode <= m[2:0];
      sleep_req <= 1'b1;
      wt(3);
      chk(afi, e);
      rd(pgate_pkg::OFS_PIN_IN, e);
      wr(pgate_pkg::OFS_IRQ_STATUS, 8'hFF);
      sleep_req <= 1'b0;
      wt(3);
      rd(pgate_pkg::OFS_IRQ_STATUS, e ^ 8'h03 ? 8'h02 : 8'h00);
    end
    // Reset in mid-run drops a pull-up that software had turned on.
    wr(pgate_pkg::OFS_PORT_DIR, 8'h00);
    wr(pgate_pkg::OFS_PORT_OUT, 8'hFF);
    wt(3);
    chk(pullup_en, 8'hFF);
    #30 rst_b = 1'b0;
    #1 chk(pullup_en, 8'h00);
    @(posedge clk);
    rst_b <= 1'b1;
    rd(pgate_pkg::OFS_PORT_OUT, 8'h00);
    wt(3);
    close_out();
  end
endmodule // testbench
`default_nettype wire
